// ---- design/vps_pkg.sv ----
/*
 * vps_pkg: register map, field positions, reset values and carrier types
 * for the video port sync and direction block.
 * Assumes a 32-bit APB register bus and one system clock.
 */
package vps_pkg;

  localparam int unsigned ADDR_W = 12;

  // register byte addresses
  localparam logic [11:0] OFS_MODE1  = 12'h000;
  localparam logic [11:0] OFS_MODE2  = 12'h004;
  localparam logic [11:0] OFS_STATUS = 12'h008;
  localparam logic [11:0] OFS_DATA   = 12'h00C;

  // first mode control register fields
  localparam int unsigned M1_MASTER  = 0;
  localparam int unsigned M1_ENCODE  = 1;
  localparam int unsigned M1_HINV    = 2;
  localparam int unsigned M1_FORMAT  = 3;
  localparam int unsigned M1_SIGNED  = 4;
  localparam int unsigned M1_CLKDIV2 = 5;
  localparam logic [5:0]  M1_RESET   = 6'h00;
  localparam int unsigned M1_W       = 6;

  // second mode control register fields
  localparam int unsigned M2_FINV    = 3;

  // status fields
  localparam int unsigned ST_VBLANK  = 0;
  localparam int unsigned ST_HBLANK  = 1;
  localparam int unsigned ST_FIELD   = 2;
  localparam int unsigned ST_STALL   = 3;
  localparam int unsigned ST_OVF     = 4;
  localparam int unsigned ST_UNF     = 5;
  localparam int unsigned ST_LVL_LO  = 8;

  // data register: read shows a valid flag above the byte
  localparam int unsigned DATA_VALID = 8;

  localparam logic [7:0] CHROMA_MSB = 8'h80;
  localparam logic [7:0] IDLE_BYTE  = 8'h00;

  typedef enum logic [0:0] {
    VPS_FMT_CHROMA_FIRST = 1'b0,
    VPS_FMT_LUMA_FIRST   = 1'b1
  } vps_format_e;

  typedef struct packed {
    logic vblank;
    logic hblank;
    logic field;
  } vps_sync_s;

  typedef struct packed {
    logic        clkdiv2;
    logic        chroma_signed;
    vps_format_e format;
    logic        hinv;
    logic        encode;
    logic        master;
  } vps_mode_s;

endpackage : vps_pkg

// ---- design/vps_fifo.sv ----
/*
 * vps_fifo: flip-flop FIFO with valid/ready on both sides and flush.
 * Assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/1ns
module vps_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 32,
  parameter int unsigned LVL_W = $clog2(DEPTH + 1)
) (
  input  wire logic             clk_sys_i,
  input  wire logic             rst_n_i,
  input  wire logic             flush_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o,
  output logic      [LVL_W-1:0] level_o
);
  localparam int unsigned PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PTR_W-1:0] wr_q;
  logic [PTR_W-1:0] rd_q;
  logic [LVL_W-1:0] cnt_q;
  logic             push;
  logic             pop;

  function automatic logic [PTR_W-1:0] inc(input logic [PTR_W-1:0] p);
    inc = (p == PTR_W'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : inc

  assign in_ready_o  = (cnt_q != LVL_W'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o  = mem_q[rd_q];
  assign level_o     = cnt_q;
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || flush_i) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= inc(wr_q);
      end
      if (pop) begin
        rd_q <= inc(rd_q);
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

endmodule : vps_fifo

// ---- design/vps_top.sv ----
/*
 * vps_top: video port sync generation/reception, coding direction,
 * video byte bus with FIFO, clock output and APB register slave.
 * Assumes the video clock input is synchronous to clk_sys_i and at most
 * half its rate; video timing is advanced on each sampled rising edge.
 */
`timescale 1ns/1ns
module vps_top
  import vps_pkg::*;
#(
  parameter int unsigned H_TOTAL  = 1716,
  parameter int unsigned H_ACTIVE = 1440,
  parameter int unsigned V_TOTAL  = 262,
  parameter int unsigned V_ACTIVE = 243,
  parameter int unsigned FIFO_D   = 32
) (
  input  wire logic              clk_sys_i,
  input  wire logic              rst_n_i,
  // apb slave
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic      [31:0]       prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  // video port
  input  wire logic              video_clock_in_i,
  output logic                   video_clock_out_o,
  input  wire logic              vblank_i,
  output logic                   vblank_o,
  output logic                   vblank_oe_n_o,
  input  wire logic              hblank_i,
  output logic                   hblank_o,
  output logic                   hblank_oe_n_o,
  input  wire logic              first_field_i,
  output logic                   first_field_o,
  output logic                   first_field_oe_n_o,
  input  wire logic [7:0]        video_byte_bus_i,
  output logic      [7:0]        video_byte_bus_o,
  output logic                   video_byte_bus_oe_n_o,
  input  wire logic              stall_i,
  output logic                   coding_direction_flag_o
);

  localparam int unsigned LVL_W = $clog2(FIFO_D + 1);

  ////////////////////////////////////////////////////////////////////////
  // mode registers and status flags

  vps_mode_s        mode_q;
  logic             finv_q;
  logic             ovf_q;
  logic             unf_q;
  logic             ovf_set;
  logic             unf_set;

  logic             apb_access;
  logic             apb_wr_data;
  logic             apb_rd_data;
  logic             apb_commit;
  logic             mode_wr;
  logic             status_wr;

  logic             f_in_valid;
  logic             f_in_ready;
  logic [7:0]       f_in_data;
  logic             f_out_valid;
  logic             f_out_ready;
  logic [7:0]       f_out_data;
  logic [LVL_W-1:0] f_level;
  logic             flush;

  ////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state; a decode-mode data write waits while the fifo is full

  assign apb_access  = psel_i & penable_i & ~pready_o;
  assign apb_wr_data = apb_access & pwrite_i & (paddr_i == OFS_DATA) & ~mode_q.encode;
  assign apb_rd_data = apb_access & ~pwrite_i & (paddr_i == OFS_DATA) & mode_q.encode;
  assign apb_commit  = apb_access & ~(apb_wr_data & ~f_in_ready);
  assign mode_wr     = apb_commit & pwrite_i & (paddr_i == OFS_MODE1);
  assign status_wr   = apb_commit & pwrite_i & (paddr_i == OFS_STATUS);
  // any first mode register write (direction or mode) empties the fifo so stale bytes never leak; a second mode register write does not
  assign flush       = mode_wr;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= apb_commit;
      pslverr_o <= apb_commit & ~((paddr_i == OFS_MODE1) || (paddr_i == OFS_MODE2) ||
                                  (paddr_i == OFS_STATUS) || (paddr_i == OFS_DATA));
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      mode_q <= vps_mode_s'(M1_RESET);
      finv_q <= 1'b0;
    end else if (apb_commit && pwrite_i) begin
      if (paddr_i == OFS_MODE1) begin
        mode_q <= vps_mode_s'(pwdata_i[M1_W-1:0]);
      end else if (paddr_i == OFS_MODE2) begin
        finv_q <= pwdata_i[M2_FINV];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // video clock sampling and clock output

  logic video_clock_in_q;
  logic tick;
  logic half_q;

  assign tick = video_clock_in_i & ~video_clock_in_q;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      video_clock_in_q            <= 1'b0;
      half_q            <= 1'b0;
      video_clock_out_o <= 1'b0;
    end else begin
      video_clock_in_q <= video_clock_in_i;
      if (tick) begin
        half_q <= ~half_q;
      end
      video_clock_out_o <= mode_q.clkdiv2 ? half_q : video_clock_in_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // master timing counters

  logic [15:0] h_cnt_q;
  logic [15:0] v_cnt_q;
  logic        fld_q;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      h_cnt_q <= '0;
      v_cnt_q <= '0;
      fld_q   <= 1'b1;
    end else if (tick) begin
      if (h_cnt_q == 16'(H_TOTAL - 1)) begin
        h_cnt_q <= '0;
        if (v_cnt_q == 16'(V_TOTAL - 1)) begin
          v_cnt_q <= '0;
          fld_q   <= ~fld_q;
        end else begin
          v_cnt_q <= v_cnt_q + 16'h0001;
        end
      end else begin
        h_cnt_q <= h_cnt_q + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sync: true-sense view inside, pin polarity applied at the boundary

  vps_sync_s gen_sync;
  vps_sync_s cur_sync;
  logic      active;

  assign gen_sync.vblank = (v_cnt_q >= 16'(V_ACTIVE));
  assign gen_sync.hblank = (h_cnt_q >= 16'(H_ACTIVE));
  assign gen_sync.field  = fld_q;

  always_comb begin
    if (mode_q.master) begin
      cur_sync = gen_sync;
    end else begin
      cur_sync.vblank = vblank_i;
      cur_sync.hblank = hblank_i ^ mode_q.hinv;
      cur_sync.field  = first_field_i ^ finv_q;
    end
  end

  assign active = ~cur_sync.vblank & ~cur_sync.hblank;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      vblank_o           <= 1'b0;
      hblank_o           <= 1'b0;
      first_field_o      <= 1'b0;
      vblank_oe_n_o      <= 1'b1;
      hblank_oe_n_o      <= 1'b1;
      first_field_oe_n_o <= 1'b1;
    end else begin
      vblank_o           <= gen_sync.vblank;
      hblank_o           <= gen_sync.hblank ^ mode_q.hinv;
      first_field_o      <= gen_sync.field ^ finv_q;
      vblank_oe_n_o      <= ~mode_q.master;
      hblank_oe_n_o      <= ~mode_q.master;
      first_field_oe_n_o <= ~mode_q.master;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sample phase and chroma sign handling

  logic phase_q;
  logic is_chroma;

  // offset binary inside; signed mode flips the chroma msb both ways
  function automatic logic [7:0] conv(input logic [7:0] b, input logic chroma,
                                      input logic sgn);
    conv = (chroma && sgn) ? (b ^ CHROMA_MSB) : b;
  endfunction : conv

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      phase_q <= 1'b0;
    end else if (tick) begin
      phase_q <= active ? ~phase_q : 1'b0;
    end
  end

  assign is_chroma = (mode_q.format == VPS_FMT_CHROMA_FIRST) ? ~phase_q : phase_q;

  ////////////////////////////////////////////////////////////////////////
  // fifo: video side fills on encode, apb side fills on decode

  logic vid_take;
  logic vid_give;

  assign vid_take = tick & active & mode_q.encode & ~stall_i;
  assign vid_give = tick & active & ~mode_q.encode;

  assign f_in_valid  = mode_q.encode ? vid_take : (apb_wr_data & apb_commit);
  assign f_in_data   = mode_q.encode ?
                       conv(video_byte_bus_i, is_chroma, mode_q.chroma_signed) :
                       pwdata_i[7:0];
  assign f_out_ready = mode_q.encode ? (apb_rd_data & apb_commit) : vid_give;
  assign ovf_set     = vid_take & ~f_in_ready;
  assign unf_set     = vid_give & ~f_out_valid;

  vps_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_D),
    .LVL_W (LVL_W)
  ) u_fifo (
    .clk_sys_i   (clk_sys_i),
    .rst_n_i     (rst_n_i),
    .flush_i     (flush),
    .in_valid_i  (f_in_valid),
    .in_ready_o  (f_in_ready),
    .in_data_i   (f_in_data),
    .out_valid_o (f_out_valid),
    .out_ready_i (f_out_ready),
    .out_data_o  (f_out_data),
    .level_o     (f_level)
  );

  // sticky flags: a new event wins over a same-cycle write-one clear
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      ovf_q <= 1'b0;
      unf_q <= 1'b0;
    end else begin
      ovf_q <= ovf_set | (ovf_q & ~(status_wr & pwdata_i[ST_OVF]));
      unf_q <= unf_set | (unf_q & ~(status_wr & pwdata_i[ST_UNF]));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // byte bus drive and coding direction

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      video_byte_bus_o        <= IDLE_BYTE;
      video_byte_bus_oe_n_o   <= 1'b1;
      coding_direction_flag_o <= 1'b0;
    end else begin
      coding_direction_flag_o <= mode_q.encode;
      video_byte_bus_oe_n_o   <= mode_q.encode;
      if (vid_give) begin
        // underrun sends the idle byte rather than repeating stale data
        video_byte_bus_o <= f_out_valid ?
                            conv(f_out_data, is_chroma, mode_q.chroma_signed) :
                            IDLE_BYTE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data

  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = '0;
    if (paddr_i == OFS_MODE1) begin
      rd_mux[M1_W-1:0] = mode_q;
    end else if (paddr_i == OFS_MODE2) begin
      rd_mux[M2_FINV] = finv_q;
    end else if (paddr_i == OFS_STATUS) begin
      rd_mux[ST_VBLANK] = cur_sync.vblank;
      rd_mux[ST_HBLANK] = cur_sync.hblank;
      rd_mux[ST_FIELD]  = cur_sync.field;
      rd_mux[ST_STALL]  = stall_i;
      rd_mux[ST_OVF]    = ovf_q;
      rd_mux[ST_UNF]    = unf_q;
      rd_mux[ST_LVL_LO +: LVL_W] = f_level;
    end else if (paddr_i == OFS_DATA) begin
      if (mode_q.encode) begin
        rd_mux[DATA_VALID] = f_out_valid;
        rd_mux[7:0]        = f_out_valid ? f_out_data : IDLE_BYTE;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      prdata_o <= '0;
    end else if (apb_commit && !pwrite_i) begin
      prdata_o <= rd_mux;
    end
  end

endmodule : vps_top

// ---- tb/vps_properties.sv ----
/*
 * vps_properties: port-level checks of the video port block.
 * Assumes binding to vps_top; sees only its ports.
 */
`timescale 1ns/1ns
module vps_properties (
  input wire logic        clk_sys_i,
  input wire logic        rst_n_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        video_clock_in_i,
  input wire logic        vblank_o,
  input wire logic        vblank_oe_n_o,
  input wire logic        hblank_oe_n_o,
  input wire logic        first_field_oe_n_o,
  input wire logic [7:0]  video_byte_bus_o,
  input wire logic        video_byte_bus_oe_n_o,
  input wire logic        coding_direction_flag_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////
  // video clock rise seen one cycle late
  logic prev_q;
  logic tick_q;
  always_ff @(posedge clk_sys_i) begin
    prev_q <= video_clock_in_i;
    tick_q <= video_clock_in_i & ~prev_q;
  end
  ////////////////////////////////////////
  a_sync_oe_same: assert property (vblank_oe_n_o == hblank_oe_n_o &&
    hblank_oe_n_o == first_field_oe_n_o) else $error("sync enables differ");
  a_encode_releases: assert property ($rose(coding_direction_flag_o) |->
    ##[0:1] video_byte_bus_oe_n_o) else $error("bus driven in encode");
  a_decode_drives: assert property ($fell(coding_direction_flag_o) |->
    ##[0:1] !video_byte_bus_oe_n_o) else $error("bus not driven in decode");
  a_ready_single: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  a_ready_cause: assert property (pready_o |-> $past(psel_i && penable_i))
    else $error("ready without access");
  a_err_in_ready: assert property (pslverr_o |-> pready_o)
    else $error("error outside ready");
  a_err_read_zero: assert property (pslverr_o && !pwrite_i |-> prdata_o == 32'h0)
    else $error("refused read not zero");
  a_vblank_on_tick: assert property (!vblank_oe_n_o && $past(!vblank_oe_n_o) &&
    $changed(vblank_o) |-> tick_q || $past(tick_q)) else $error("vblank off tick");
  a_byte_on_tick: assert property (!video_byte_bus_oe_n_o &&
    $past(!video_byte_bus_oe_n_o) && $changed(video_byte_bus_o) |->
    tick_q || $past(tick_q)) else $error("byte off tick");
endmodule : vps_properties

// ---- tb/vps_video_model.sv ----
/*
 * vps_video_model: external video source with free-running clock.
 * Assumes the bench resolves shared pins from the enables.
 */
`timescale 1ns/1ns
module vps_video_model #(
  parameter int unsigned H_T = 8,
  parameter int unsigned H_A = 6,
  parameter int unsigned V_T = 4,
  parameter int unsigned V_A = 3
) (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  output logic            video_clock_in_o,
  output logic            vblank_o,
  output logic            hblank_o,
  output logic            field_o,
  output logic [7:0]      byte_o
);
  logic [1:0]  div_q = 2'h0;
  int unsigned h_q   = 0;
  int unsigned v_q   = 0;
  logic        fld_q = 1'b1;
  logic [7:0]  pix_q = 8'h00;
  // quarter of the system rate so every rise is sampled
  always_ff @(posedge clk_sys_i) begin
    div_q <= div_q + 2'h1;
    if (div_q == 2'h3) begin
      pix_q <= pix_q + 8'h01;
      h_q   <= (h_q == H_T - 1) ? 0 : h_q + 1;
      if (h_q == H_T - 1) begin
        v_q <= (v_q == V_T - 1) ? 0 : v_q + 1;
        if (v_q == V_T - 1) fld_q <= ~fld_q;
      end
    end
  end
  assign video_clock_in_o   = div_q[1];
  assign vblank_o = (v_q >= V_A);
  assign hblank_o = (h_q >= H_A);
  assign field_o  = fld_q;
  assign byte_o   = pix_q;
endmodule : vps_video_model

// ---- tb/test_video_port_sync_and_direction.sv ----
/*
 * test_video_port_sync_and_direction: register rows, then sync, direction,
 * clock output and fifo cases. Assumes vps_top with short video timing.
 */
`timescale 1ns/1ns
module test_video_port_sync_and_direction;
  import vps_pkg::*;
  typedef struct packed {
    logic wr; logic [11:0] adr; logic [31:0] wd; logic [31:0] rd; logic err;
  } vps_row_s;
  logic clk_sys_i = 1'b0, rst_n_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0;
  logic pwrite_i = 1'b0, stall_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0, prdata_o, r;
  logic pready_o, pslverr_o, video_clock_out_o, vblank_o, hblank_o, first_field_o, e, f;
  logic vblank_oe_n_o, hblank_oe_n_o, first_field_oe_n_o, video_byte_bus_oe_n_o;
  logic coding_direction_flag_o, m_vb, m_hb, m_ff;
  logic [7:0] video_byte_bus_o, m_byte;
  wire logic vblank_i, hblank_i, first_field_i, video_clock_in_i;
  wire logic [7:0] video_byte_bus_i;
  int bad_count = 0, n_tests = 0, vb, hb, ff, co;
  vps_row_s rows[8] = '{'{1'b0, OFS_MODE1, 32'h0, 32'h0, 1'b0},
    '{1'b0, OFS_MODE2, 32'h0, 32'h0, 1'b0}, '{1'b1, OFS_MODE2, 32'h8, 32'h0, 1'b0},
    '{1'b0, OFS_MODE2, 32'h0, 32'h8, 1'b0}, '{1'b1, OFS_MODE1, 32'h3F, 32'h0, 1'b0},
    '{1'b0, OFS_MODE1, 32'h0, 32'h3F, 1'b0}, '{1'b0, 12'h010, 32'h0, 32'h0, 1'b1},
    '{1'b1, 12'h010, 32'h5, 32'h0, 1'b1}};
  always #25 clk_sys_i = ~clk_sys_i;
  // whoever is enabled owns the shared pin
  assign vblank_i = vblank_oe_n_o ? m_vb : vblank_o;
  assign hblank_i = hblank_oe_n_o ? m_hb : hblank_o;
  assign first_field_i = first_field_oe_n_o ? m_ff : first_field_o;
  assign video_byte_bus_i = video_byte_bus_oe_n_o ? m_byte : video_byte_bus_o;
  vps_top #(.H_TOTAL(8), .H_ACTIVE(6), .V_TOTAL(4), .V_ACTIVE(3), .FIFO_D(32)) i_dut (
    .clk_sys_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
    .pready_o, .pslverr_o, .video_clock_in_i, .video_clock_out_o, .vblank_i, .vblank_o,
    .vblank_oe_n_o, .hblank_i, .hblank_o, .hblank_oe_n_o, .first_field_i, .first_field_o,
    .first_field_oe_n_o, .video_byte_bus_i, .video_byte_bus_o, .video_byte_bus_oe_n_o,
    .stall_i, .coding_direction_flag_o);
  vps_video_model i_model (.clk_sys_i, .rst_n_i, .video_clock_in_o(video_clock_in_i), .vblank_o(m_vb),
    .hblank_o(m_hb), .field_o(m_ff), .byte_o(m_byte));
  ////////////////////////////////////////
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task report_and_stop;
    if (bad_count == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys_i);
    psel_i <= 1'b1; pwrite_i <= wr; paddr_i <= a; pwdata_i <= d;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
      if (n > 200) begin
        chk("pready wait", 32'h0, 32'h1);
        report_and_stop();
      end
    end while (pready_o !== 1'b1);
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0; penable_i <= 1'b0;
  endtask : apb
  // one window is two whole fields at the short timing
  task count;
    logic pc;
    vb = 0; hb = 0; ff = 0; co = 0;
    pc = video_clock_out_o;
    repeat (256) begin
      @(posedge clk_sys_i);
      vb += vblank_o; hb += hblank_o; ff += first_field_o;
      co += (video_clock_out_o && !pc);
      pc = video_clock_out_o;
    end
  endtask : count
  // bounded waits on the model's vblank and on the decoded byte
  task wait_vb(input logic lvl);
    int n;
    n = 0;
    while (m_vb !== lvl) begin
      @(posedge clk_sys_i);
      n++;
      if (n > 300) begin
        chk("vblank wait", 32'h0, 32'h1);
        report_and_stop();
      end
    end
  endtask : wait_vb
  task wait_byte(input logic [7:0] old);
    int n;
    n = 0;
    while (video_byte_bus_o === old) begin
      @(posedge clk_sys_i);
      n++;
      if (n > 300) begin
        chk("byte wait", 32'h0, 32'h1);
        report_and_stop();
      end
    end
  endtask : wait_byte
  // two bytes queued in vertical blank come out at the next field's first active ticks
  task dec_pair(input logic [31:0] md, input logic [7:0] x0, input logic [7:0] x1);
    apb(1'b1, OFS_MODE1, md);
    wait_vb(1'b0);
    wait_vb(1'b1);
    apb(1'b1, OFS_DATA, 32'h11);
    apb(1'b1, OFS_DATA, 32'h22);
    wait_byte(8'h00);
    chk("first byte", video_byte_bus_o, x0);
    wait_byte(x0);
    chk("second byte", video_byte_bus_o, x1);
    wait_byte(x1);
    chk("idle byte", video_byte_bus_o, IDLE_BYTE);
  endtask : dec_pair
  ////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    chk("sync release", {vblank_oe_n_o, hblank_oe_n_o, first_field_oe_n_o}, 3'h7);
    chk("direction reset", coding_direction_flag_o, 1'b0);
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].adr, rows[i].wd);
      chk("slverr", e, rows[i].err);
      if (!rows[i].wr) chk("rdata", r, rows[i].rd);
    end
    apb(1'b1, OFS_MODE1, 32'h0);
    apb(1'b1, OFS_MODE2, 32'h0);
    repeat (4) @(posedge clk_sys_i);
    chk("slave sync oe", {vblank_oe_n_o, hblank_oe_n_o, first_field_oe_n_o}, 3'h7);
    chk("decode bus oe", video_byte_bus_oe_n_o, 1'b0);
    chk("decode dir", coding_direction_flag_o, 1'b0);
    f = m_ff;
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("field status", r[ST_FIELD], f);
    apb(1'b1, OFS_MODE2, 32'h8);
    f = m_ff;
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("field inverted", r[ST_FIELD], !f);
    apb(1'b1, OFS_MODE2, 32'h0);
    apb(1'b1, OFS_MODE1, 32'h1);
    repeat (8) @(posedge clk_sys_i);
    chk("master sync oe", {vblank_oe_n_o, hblank_oe_n_o, first_field_oe_n_o}, 3'h0);
    count();
    chk("vblank cycles", 32'(vb), 32'd64);
    chk("hblank cycles", 32'(hb), 32'd64);
    chk("field cycles", 32'(ff), 32'd128);
    chk("clkout rises", 32'(co), 32'd64);
    apb(1'b1, OFS_MODE1, 32'h25);
    repeat (8) @(posedge clk_sys_i);
    count();
    chk("hblank inverted", 32'(hb), 32'd192);
    chk("clkout half", 32'(co), 32'd32);
    stall_i <= 1'b1;
    apb(1'b1, OFS_MODE1, 32'h2);
    repeat (4) @(posedge clk_sys_i);
    chk("encode dir", coding_direction_flag_o, 1'b1);
    chk("encode bus oe", video_byte_bus_oe_n_o, 1'b1);
    repeat (256) @(posedge clk_sys_i);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("stalled level", r[13:8], 6'h00);
    stall_i <= 1'b0;
    repeat (512) @(posedge clk_sys_i);
    stall_i <= 1'b1;
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("full level", r[13:8], 6'h20);
    chk("overflow", r[ST_OVF], 1'b1);
    for (int i = 0; i < 33; i++) begin
      apb(1'b0, OFS_DATA, 32'h0);
      chk("pop valid", r[DATA_VALID], (i < 32));
    end
    apb(1'b1, OFS_STATUS, 32'h10);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("overflow cleared", r[ST_OVF], 1'b0);
    dec_pair(32'h10, 8'h91, 8'h22);
    dec_pair(32'h18, 8'h11, 8'hA2);
    report_and_stop();
  end
endmodule : test_video_port_sync_and_direction
bind vps_top vps_properties i_prop (.*);
